// File: tb/sec_bus_mon.sv
`timescale 1ns/10ps
// Secondary bus side: flags any shortened high phase
module sec_bus_mon #(
  parameter int HALF_CYC = 2
) (
  input  wire logic       clk,
  input  wire logic [6:0] sclk,
  input  wire logic       clr,
  output logic      [6:0] seen,
  output logic      [6:0] bad
);
  int hi [7] = '{default: 0};
  initial bad = 7'h00;
  // Activity and high-phase length per output
  always @(posedge clk)
    for (int i = 0; i < 7; i++)
    begin
      seen[i] <= clr ? 1'b0 : (seen[i] | sclk[i]);
      hi[i] <= sclk[i] ? hi[i] + 1 : 0;
      if (!sclk[i] && hi[i] != 0 && hi[i] != HALF_CYC)
        bad[i] <= 1'b1;
    end
endmodule // sec_bus_mon

// File: tb/tb_bridge_power_and_clock_ctrl.sv
`timescale 1ns/10ps
module tb_bridge_power_and_clock_ctrl;
  localparam int HC = 2;
  localparam logic [7:0] GA = bridge_pkg::OFS_GEN_SETTINGS;
  localparam logic [7:0] CA = bridge_pkg::OFS_CLK_GATE;
  logic clk = 1'b0, nrst = 1'b0, lfr_n = 1'b1, glob_rst_n = 1'b1;
  logic wr = 1'b0, rd = 1'b0, d3 = 1'b0, clr = 1'b0;
  logic [7:0] addr = 8'h00, a, mv;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0, rdata, gm, cm;
  logic pf, bcn, stp;
  logic [2:0] sl, dl;
  logic [11:0] aer;
  logic [1:0] sc;
  logic [6:0] sclk, seen, bad, en;
  int failures = 0;
  int comparisons = 0;
  // Reference clock never stops, D3 included
  always #2 clk = ~clk;
  bridge_power_and_clock_ctrl #(.HALF_CYC(HC)) u_dut (
    .clk(clk), .nrst(nrst), .link_fund_reset_n(lfr_n), .global_reset_input_n(glob_rst_n),
    .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wd),
    .cfg_rdata(rdata), .pm_state_d3(d3), .prefetch_to_line(pf),
    .advertised_shallow_exit_latency(sl), .advertised_deep_exit_latency(dl),
    .aer_next_offset(aer), .wake_use_beacon(bcn), .min_power_scale(sc),
    .min_power_value(mv), .secondary_clock_output(sclk), .sec_clocks_stopped(stp));
  sec_bus_mon #(.HALF_CYC(HC)) u_mon (.clk(clk), .sclk(sclk), .clr(clr), .seen(seen), .bad(bad));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One write, model follows the byte lanes
  task automatic wrt(logic [7:0] ad, logic [3:0] b, logic [31:0] d);
    @(negedge clk);
    addr = ad;
    be = b;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    for (int i = 0; i < 4; i++)
      if (b[i] && ad == GA) gm[8*i +: 8] = d[8*i +: 8];
      else if (b[i] && ad == CA) cm[8*i +: 8] = d[8*i +: 8];
    gm &= 32'h000fffff;
    cm &= 32'h0000007f;
  endtask
  function automatic logic [31:0] exp_rd(logic [7:0] ad);
    return (ad == GA) ? gm : (ad == CA) ? cm : 32'h0;
  endfunction
  task automatic rdc(logic [7:0] ad);
    @(negedge clk);
    addr = ad;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("cfg_rdata", exp_rd(ad), rdata);
  endtask
  task automatic outs();
    chk("prefetch_to_line", !gm[19], pf);
    chk("shallow_lat", gm[18:16], sl);
    chk("deep_lat", gm[15:13], dl);
    chk("aer_next_offset", gm[12] ? 12'h150 : 12'h000, aer);
    chk("wake_use_beacon", gm[10], bcn);
    chk("min_power_scale", gm[9:8], sc);
    chk("min_power_value", gm[7:0], mv);
  endtask
  // Let gates settle, then watch each output run or stay low
  task automatic clks();
    en = ~cm[6:0] & ~{7{d3 & gm[11]}};
    clr = 1'b1;
    repeat (2*HC+2) @(negedge clk);
    clr = 1'b0;
    repeat (4*HC) @(negedge clk);
    chk("clock_activity", en, seen);
    chk("sec_clocks_stopped", en == 7'h00, stp);
  endtask
  initial
  begin
    void'($urandom(86));
    gm = {12'h0, bridge_pkg::GEN_RST};
    cm = 32'h0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    rdc(GA);
    rdc(CA);
    outs();
    clks();
    wrt(CA, 4'hf, 32'hffffffff);
    rdc(CA);
    clks();
    wrt(CA, 4'h1, 32'h00000000);
    wrt(GA, 4'hf, 32'h00000800);
    d3 = 1'b1;
    clks();
    // Random traffic over mapped and unmapped offsets
    for (int k = 0; k < 30; k++)
    begin
      a = (k % 3 == 0) ? CA : (k % 3 == 1) ? GA : 8'hd0;
      wrt(a, 4'($urandom), $urandom);
      rdc(a);
      outs();
      d3 = 1'($urandom);
      clks();
    end
    // Global then fundamental reset; writes while held are dropped
    for (int k = 0; k < 2; k++)
    begin
      wrt(GA, 4'hf, 32'h000fffff);
      wrt(CA, 4'h1, 32'h00000055);
      glob_rst_n = (k != 0);
      lfr_n = (k == 0);
      repeat (3) @(negedge clk);
      wrt(CA, 4'h1, 32'h0000007f);
      glob_rst_n = 1'b1;
      lfr_n = 1'b1;
      repeat (4) @(negedge clk);
      gm = (gm & 32'h00000c00) | {12'h0, bridge_pkg::GEN_RST};
      cm = 32'h0;
      rdc(GA);
      rdc(CA);
      outs();
    end
    chk("runt_pulses", 7'h00, bad);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    gm = {12'h0, bridge_pkg::GEN_RST};
    rdc(GA);
    close_out();
  end
  // Cut a hang short
  initial
  begin
    #100000;
    failures++;
    close_out();
  end
endmodule // tb_bridge_power_and_clock_ctrl

// File: verilog/bridge_pkg.sv
// Function
// - Lookahead-off bit selects line prefetch or single dword
// - Shallow exit latency copied to capability bits 8:6
// - Deep exit latency copied to capability bits 11:9
// - Channel struct bit picks next offset 000h/150h
// - Gate bit stops secondary clocks in D3
// - Beacon bit adds beacon to wake signalling
// - Two-bit scale gives minimum power multiplier
// - Minimum power value resets to zero, reprogrammable
// - Non-sticky fields reset by fundamental, global, power-on
// - Sticky gate and beacon bits survive fundamental and global resets, power-on clears them
// - Clock register bits 6:0 disable matching outputs
// - Clock register bit 7 reserved, reads zero
package bridge_pkg;
  // Register byte offsets in configuration space
  localparam logic [7:0]  OFS_GEN_SETTINGS = 8'hd4;
  localparam logic [7:0]  OFS_CLK_GATE     = 8'hd8;
  // Field positions in the general settings register
  localparam int          BIT_LOOKAHEAD    = 19;
  localparam int          LSB_SHALLOW_LAT  = 16;
  localparam int          LSB_DEEP_LAT     = 13;
  localparam int          BIT_VC_STRUCT    = 12;
  localparam int          BIT_CLK_GATE_D3  = 11;
  localparam int          BIT_BEACON       = 10;
  localparam int          LSB_MIN_SCALE    = 8;
  localparam int          LSB_MIN_VALUE    = 0;
  localparam int          GEN_BITS         = 20;
  // Reset values and masks
  localparam logic [19:0] GEN_RST          = 20'h6c000;
  localparam logic [19:0] GEN_STICKY       = 20'h00c00;
  localparam logic [7:0]  CLK_GATE_RST     = 8'h00;
  localparam logic [7:0]  CLK_GATE_WMASK   = 8'h7f;
  // Next-offset values of the error reporting header
  localparam logic [11:0] NEXT_OFS_NONE    = 12'h000;
  localparam logic [11:0] NEXT_OFS_VC      = 12'h150;
  // Secondary clocks and their timing
  localparam int          NUM_SEC_CLK      = 7;
  localparam int          CLK_PERIOD_PS    = 4000;
  localparam int          SEC_HALF_NS      = 15;
  localparam int          SEC_HALF_CYC     = (SEC_HALF_NS * 1000) / CLK_PERIOD_PS;
endpackage

// File: verilog/bridge_power_and_clock_ctrl.sv
`timescale 1ns/10ps
module bridge_power_and_clock_ctrl #(
  parameter int HALF_CYC = bridge_pkg::SEC_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        link_fund_reset_n,
  input  wire logic        global_reset_input_n,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  input  wire logic        pm_state_d3,
  output logic             prefetch_to_line,
  output logic      [2:0]  advertised_shallow_exit_latency,
  output logic      [2:0]  advertised_deep_exit_latency,
  output logic      [11:0] aer_next_offset,
  output logic             wake_use_beacon,
  output logic      [1:0]  min_power_scale,
  output logic      [7:0]  min_power_value,
  output logic      [6:0]  secondary_clock_output,
  output logic             sec_clocks_stopped
);
  localparam int GB = bridge_pkg::GEN_BITS;

  // Byte-enable merge of a write into a 32-bit word
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    return res;
  endfunction

  logic [1:0]    fund_sync_r, fund_sync_nxt;
  logic [1:0]    glob_sync_r, glob_sync_nxt;
  logic          soft_clr;
  logic [GB-1:0] gen_r, gen_nxt;
  logic [7:0]    gate_r, gate_nxt;
  logic [11:0]   next_ofs_r, next_ofs_nxt;
  logic [31:0]   rdata_r, rdata_nxt;
  logic [31:0]   gen_word, gate_word;
  logic [31:0]   gen_merged, gate_merged;
  logic          prefetch_r, prefetch_nxt;
  logic          wr_gen, wr_gate;
  clk_gate_if    cgi ();

  // Reset pins cross into clk through two flops
  always_comb
  begin
    fund_sync_nxt = {fund_sync_r[0], link_fund_reset_n};
    glob_sync_nxt = {glob_sync_r[0], global_reset_input_n};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fund_sync_r <= 2'b00;
      glob_sync_r <= 2'b00;
    end
    else
    begin
      fund_sync_r <= fund_sync_nxt;
      glob_sync_r <= glob_sync_nxt;
    end
  end

  assign soft_clr = !fund_sync_r[1] || !glob_sync_r[1];
  assign wr_gen   = cfg_wr && (cfg_addr == bridge_pkg::OFS_GEN_SETTINGS);
  assign wr_gate  = cfg_wr && (cfg_addr == bridge_pkg::OFS_CLK_GATE);
  assign gen_word  = {{(32 - GB){1'b0}}, gen_r};
  assign gate_word = {24'h000000, gate_r};
  // Byte-lane merge of the incoming write
  assign gen_merged  = merge_be(gen_word, cfg_wdata, cfg_be);
  assign gate_merged = merge_be(gate_word, cfg_wdata, cfg_be);

  // Register next values, readback and derived header field
  always_comb
  begin
    gen_nxt  = gen_r;
    gate_nxt = gate_r;
    if (soft_clr)
    begin
      gen_nxt  = (gen_r & bridge_pkg::GEN_STICKY) | (bridge_pkg::GEN_RST & ~bridge_pkg::GEN_STICKY);
      gate_nxt = bridge_pkg::CLK_GATE_RST;
    end
    else
    begin
      if (wr_gen)
        gen_nxt = gen_merged[GB-1:0];
      if (wr_gate)
        gate_nxt = gate_merged[7:0] & bridge_pkg::CLK_GATE_WMASK;
    end
    prefetch_nxt = !gen_nxt[bridge_pkg::BIT_LOOKAHEAD];
    next_ofs_nxt = gen_nxt[bridge_pkg::BIT_VC_STRUCT] ? bridge_pkg::NEXT_OFS_VC
                                                       : bridge_pkg::NEXT_OFS_NONE;
    rdata_nxt = rdata_r;
    if (cfg_rd)
    begin
      case (cfg_addr)
        bridge_pkg::OFS_GEN_SETTINGS: rdata_nxt = gen_word;
        bridge_pkg::OFS_CLK_GATE:     rdata_nxt = gate_word;
        default:                      rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Sticky bits only cleared by the auxiliary power-on reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gen_r      <= bridge_pkg::GEN_RST;
      gate_r     <= bridge_pkg::CLK_GATE_RST;
      next_ofs_r <= bridge_pkg::NEXT_OFS_NONE;
      prefetch_r <= !bridge_pkg::GEN_RST[bridge_pkg::BIT_LOOKAHEAD];
      rdata_r    <= 32'h00000000;
    end
    else
    begin
      gen_r      <= gen_nxt;
      gate_r     <= gate_nxt;
      next_ofs_r <= next_ofs_nxt;
      prefetch_r <= prefetch_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // Clock requests: per-output disable plus D3 stop
  assign cgi.want_on = ~gate_r[6:0] & ~{7{pm_state_d3 && gen_r[bridge_pkg::BIT_CLK_GATE_D3]}};

  sec_clk_gen #(
    .HALF_CYC (HALF_CYC)
  ) u_gen (
    .clk  (clk),
    .nrst (nrst),
    .gi   (cgi.gen)
  );

  // Outputs straight from flops
  assign cfg_rdata                       = rdata_r;
  assign prefetch_to_line                = prefetch_r;
  assign advertised_shallow_exit_latency = gen_r[bridge_pkg::LSB_SHALLOW_LAT +: 3];
  assign advertised_deep_exit_latency    = gen_r[bridge_pkg::LSB_DEEP_LAT +: 3];
  assign aer_next_offset                 = next_ofs_r;
  assign wake_use_beacon                 = gen_r[bridge_pkg::BIT_BEACON];
  assign min_power_scale                 = gen_r[bridge_pkg::LSB_MIN_SCALE +: 2];
  assign min_power_value                 = gen_r[bridge_pkg::LSB_MIN_VALUE +: 8];
  assign secondary_clock_output          = cgi.clk_out;
  assign sec_clocks_stopped              = cgi.all_stopped;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Field copies from an accepted config write
  a_prefetch_follow: assert property (
    wr_gen && cfg_be[2] && !soft_clr
    |=> prefetch_to_line == !$past(cfg_wdata[bridge_pkg::BIT_LOOKAHEAD]))
    else $error("prefetch mode not taken from write");
  a_shallow_copy: assert property (
    wr_gen && cfg_be[2] && !soft_clr
    |=> advertised_shallow_exit_latency == $past(cfg_wdata[bridge_pkg::LSB_SHALLOW_LAT +: 3]))
    else $error("shallow latency not copied");
  a_deep_copy: assert property (
    wr_gen && cfg_be[1] && !soft_clr
    |=> advertised_deep_exit_latency == $past(cfg_wdata[bridge_pkg::LSB_DEEP_LAT +: 3]))
    else $error("deep latency not copied");
  a_beacon_map: assert property (
    wr_gen && cfg_be[1] && !soft_clr
    |=> wake_use_beacon == $past(cfg_wdata[bridge_pkg::BIT_BEACON]))
    else $error("beacon mode not taken from write");
  a_scale_copy: assert property (
    wr_gen && cfg_be[1] && !soft_clr
    |=> min_power_scale == $past(cfg_wdata[bridge_pkg::LSB_MIN_SCALE +: 2]))
    else $error("power scale not copied");
  a_value_copy: assert property (
    wr_gen && cfg_be[0] && !soft_clr
    |=> min_power_value == $past(cfg_wdata[bridge_pkg::LSB_MIN_VALUE +: 8]))
    else $error("power value not copied");

  // Next-offset field of the error reporting header
  a_next_ofs_map: assert property (
    aer_next_offset == (gen_r[bridge_pkg::BIT_VC_STRUCT] ? bridge_pkg::NEXT_OFS_VC
                                                         : bridge_pkg::NEXT_OFS_NONE))
    else $error("next offset does not follow enable");
  a_vc_follow: assert property (
    wr_gen && cfg_be[1] && !soft_clr
    |=> aer_next_offset == ($past(cfg_wdata[bridge_pkg::BIT_VC_STRUCT]) ? bridge_pkg::NEXT_OFS_VC
                                                                          : bridge_pkg::NEXT_OFS_NONE))
    else $error("next offset not taken from write");

  // Clock stopping by D3 and per-output disable
  a_d3_clock_stop: assert property (
    (pm_state_d3 && gen_r[bridge_pkg::BIT_CLK_GATE_D3] && !soft_clr && !wr_gen) [*6]
    |-> secondary_clock_output == 7'h00)
    else $error("clocks run in D3 with gating on");
  a_disable_stops: assert property (
    (gate_r[3] && !soft_clr) [*6] |-> secondary_clock_output[3] == 1'b0)
    else $error("disabled clock still toggling");
  a_gate_write: assert property (
    wr_gate && cfg_be[0] && !soft_clr
    |=> gate_r == {1'b0, $past(cfg_wdata[6:0])})
    else $error("clock disable bits not taken from write");

  // Soft reset reload and sticky bits
  a_soft_reset_val: assert property (
    soft_clr |=> (gen_r & ~bridge_pkg::GEN_STICKY) == (bridge_pkg::GEN_RST & ~bridge_pkg::GEN_STICKY)
                 && gate_r == bridge_pkg::CLK_GATE_RST)
    else $error("non-sticky field not reset");
  a_sticky_keep: assert property (
    soft_clr |=> gen_r[bridge_pkg::BIT_CLK_GATE_D3] == $past(gen_r[bridge_pkg::BIT_CLK_GATE_D3])
                 && gen_r[bridge_pkg::BIT_BEACON] == $past(gen_r[bridge_pkg::BIT_BEACON]))
    else $error("sticky bit lost on soft reset");

  // Reserved bits of the clock register read as zero
  a_reserved_zero: assert property (
    cfg_rd && cfg_addr == bridge_pkg::OFS_CLK_GATE |=> cfg_rdata[31:7] == 25'h0000000)
    else $error("reserved bit reads nonzero");

  // Main scenarios
  c_d3_stop: cover property (pm_state_d3 && gen_r[bridge_pkg::BIT_CLK_GATE_D3] ##8 sec_clocks_stopped);
  c_soft_reset: cover property (soft_clr && gen_r[bridge_pkg::BIT_BEACON]);
  c_vc_on: cover property ($rose(aer_next_offset[8]));
  c_clk_disable: cover property (wr_gate && cfg_wdata[0] && cfg_be[0]);
  c_beacon_on: cover property (wr_gen && cfg_be[1] && cfg_wdata[bridge_pkg::BIT_BEACON]);
endmodule // bridge_power_and_clock_ctrl

// File: verilog/clk_gate_if.sv
`timescale 1ns/10ps
// Carries gate requests to the clock generator and its state back
interface clk_gate_if;
  logic [6:0] want_on;
  logic [6:0] clk_out;
  logic       all_stopped;
  modport ctrl (output want_on, input clk_out, input all_stopped);
  modport gen  (input want_on, output clk_out, output all_stopped);
endinterface

// File: verilog/sec_clk_gen.sv
`timescale 1ns/10ps
module sec_clk_gen #(
  parameter int HALF_CYC = bridge_pkg::SEC_HALF_CYC
) (
  input  wire logic  clk,
  input  wire logic  nrst,
  clk_gate_if.gen    gi
);
  logic [7:0] cnt_r, cnt_nxt;
  logic       phase_r, phase_nxt;
  logic [6:0] gate_r, gate_nxt;
  logic [6:0] out_r, out_nxt;
  logic       stop_r, stop_nxt;

  // Divider, gate update only while next phase is low
  always_comb
  begin
    cnt_nxt   = cnt_r + 8'h01;
    phase_nxt = phase_r;
    if (cnt_r == 8'(HALF_CYC - 1))
    begin
      cnt_nxt   = 8'h00;
      phase_nxt = ~phase_r;
    end
    gate_nxt = phase_nxt ? gate_r : gi.want_on;
    out_nxt  = {7{phase_nxt}} & gate_nxt;
    stop_nxt = (gate_nxt == 7'h00);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r   <= 8'h00;
      phase_r <= 1'b0;
      gate_r  <= 7'h7f;
      out_r   <= 7'h00;
      stop_r  <= 1'b0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      phase_r <= phase_nxt;
      gate_r  <= gate_nxt;
      out_r   <= out_nxt;
      stop_r  <= stop_nxt;
    end
  end

  assign gi.clk_out     = out_r;
  assign gi.all_stopped = stop_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_gate_low_edge: assert property ($changed(gate_r) |-> !phase_r)
    else $error("gate changed while clock high");
  a_no_runt_rise: assert property ($rose(out_r[0]) |-> ##1 out_r[0])
    else $error("runt pulse on secondary clock");
endmodule // sec_clk_gen
